// *** sbcif_pkg.sv ***
// Package with flag positions, sizes and reset values for the interrupt flag block
package sbcif_pkg;
  localparam int unsigned FLAG_W           = 10;
  localparam int unsigned SPI_BITS         = 16;
  localparam int unsigned CNT_W            = 5;
  localparam int unsigned BIT_LIN_RESUME   = 0;
  localparam int unsigned BIT_CAN_RESUME   = 1;
  localparam int unsigned BIT_WD_RESTART   = 2;
  localparam int unsigned BIT_LOCAL_RESUME = 3;
  localparam int unsigned BIT_LIN_FAIL     = 4;
  localparam int unsigned BIT_CAN_FAIL     = 5;
  localparam int unsigned BIT_SUPPLY_FAIL  = 6;
  localparam int unsigned BIT_BAT_FAIL     = 7;
  localparam int unsigned BIT_SPI_FRAME    = 8;
  localparam int unsigned BIT_GND_OFFSET   = 9;
  localparam logic [9:0]  FLAGS_RST        = 10'h000;
  localparam logic [4:0]  CNT_RST          = 5'h00;
  localparam logic [4:0]  CNT_MAX          = 5'h1F;
  localparam logic [4:0]  CNT_GOOD         = 5'h10;
endpackage

// *** sbcif_frame_check.sv ***
// SPI frame clock counter that judges each frame's length
`timescale 1ns/1ns
module sbcif_frame_check
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic spi_frame_active,
  input  wire logic spi_sclk_edge,
  output logic      frame_ok_q,
  output logic      frame_bad_q
);
  import sbcif_pkg::*;

  logic [CNT_W-1:0] count_q;
  logic             active_q;
  logic             frame_end;

  assign frame_end = active_q && !spi_frame_active;

  // -------------------------------------------------
  // Clock counting, saturating so long frames stay bad
  // -------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_q  <= CNT_RST;
      active_q <= 1'b0;
    end else begin
      active_q <= spi_frame_active;
      if (!spi_frame_active) begin
        count_q <= CNT_RST;
      end else if (spi_sclk_edge && count_q != CNT_MAX) begin
        count_q <= count_q + 5'h01;
      end
    end
  end

  // -------------------------------------------------
  // Verdict at frame end, one-cycle pulses
  // -------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_ok_q  <= 1'b0;
      frame_bad_q <= 1'b0;
    end else begin
      frame_ok_q  <= frame_end && (count_q == CNT_GOOD);
      frame_bad_q <= frame_end && (count_q != CNT_GOOD);
    end
  end
endmodule

// *** sbcif_flags.sv ***
// Top of the interrupt flag logic: event detection and sticky flag word
`timescale 1ns/1ns
module sbcif_flags
(
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  input  wire logic                         spi_frame_active,
  input  wire logic                         spi_sclk_edge,
  input  wire logic                         spi_cmd_valid,
  input  wire logic                         ground_offset_diag,
  input  wire logic                         battery_sense,
  input  wire logic                         regulator_one_good,
  input  wire logic                         regulator_two_good,
  input  wire logic                         regulator_three_good,
  input  wire logic [1:0]                   can_fail_status,
  input  wire logic [1:0]                   lin_fail_status,
  input  wire logic                         wake_pin,
  input  wire logic                         wd_restart,
  input  wire logic                         wd_off,
  input  wire logic                         can_wake_event,
  input  wire logic                         lin_wake_event,
  input  wire logic [sbcif_pkg::FLAG_W-1:0] flag_clear,
  output logic [sbcif_pkg::FLAG_W-1:0]      irq_flags_q,
  output logic                              spi_cmd_accept_q
);
  import sbcif_pkg::*;

  logic              frame_ok;
  logic              frame_bad;
  logic              gnd_q;
  logic              bat_q;
  logic [2:0]        reg_q;
  logic [1:0]        can_q;
  logic [1:0]        lin_q;
  logic              wake_q;
  logic              prime_q;
  logic [FLAG_W-1:0] set_vec;
  logic              gnd_flag_q;
  logic              spi_flag_q;
  logic              bat_flag_q;
  logic              sup_flag_q;
  logic              canf_flag_q;
  logic              linf_flag_q;
  logic              loc_flag_q;
  logic              wdr_flag_q;
  logic              canr_flag_q;
  logic              linr_flag_q;

  function automatic logic fell(input logic prev, input logic now);
    fell = prev && !now;
  endfunction

  // Set beats clear, so an event in the clearing cycle is never lost
  function automatic logic sticky(input logic held, input logic clr, input logic evt);
    sticky = (held && !clr) || evt;
  endfunction

  sbcif_frame_check u_frame (
    .clk_sys          (clk_sys),
    .rst_n            (rst_n),
    .spi_frame_active (spi_frame_active),
    .spi_sclk_edge    (spi_sclk_edge),
    .frame_ok_q       (frame_ok),
    .frame_bad_q      (frame_bad)
  );

  // -------------------------------------------------
  // Previous input levels for edge detection
  // -------------------------------------------------
  // Prime keeps the first sample after reset from faking a change
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prime_q <= 1'b0;
      gnd_q   <= 1'b0;
      bat_q   <= 1'b0;
      reg_q   <= 3'h0;
      can_q   <= 2'h0;
      lin_q   <= 2'h0;
      wake_q  <= 1'b0;
    end else begin
      prime_q <= 1'b1;
      gnd_q   <= ground_offset_diag;
      bat_q   <= battery_sense;
      reg_q   <= {regulator_three_good, regulator_two_good, regulator_one_good};
      can_q   <= can_fail_status;
      lin_q   <= lin_fail_status;
      wake_q  <= wake_pin;
    end
  end

  // -------------------------------------------------
  // Event vector
  // -------------------------------------------------
  always_comb begin
    set_vec = FLAGS_RST;
    set_vec[BIT_SPI_FRAME]    = frame_bad;
    set_vec[BIT_GND_OFFSET]   = prime_q && (gnd_q != ground_offset_diag);
    set_vec[BIT_BAT_FAIL]     = prime_q && fell(bat_q, battery_sense);
    set_vec[BIT_SUPPLY_FAIL]  = prime_q && (fell(reg_q[0], regulator_one_good)
                                || fell(reg_q[1], regulator_two_good)
                                || fell(reg_q[2], regulator_three_good));
    set_vec[BIT_CAN_FAIL]     = prime_q && (can_q != can_fail_status);
    set_vec[BIT_LIN_FAIL]     = prime_q && (lin_q != lin_fail_status);
    set_vec[BIT_LOCAL_RESUME] = prime_q && fell(wake_q, wake_pin);
    set_vec[BIT_WD_RESTART]   = wd_restart && wd_off;
    set_vec[BIT_CAN_RESUME]   = can_wake_event;
    set_vec[BIT_LIN_RESUME]   = lin_wake_event;
  end

  // -------------------------------------------------
  // Sticky flags, one register per event kind
  // -------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gnd_flag_q <= FLAGS_RST[BIT_GND_OFFSET];
    end else begin
      gnd_flag_q <= sticky(gnd_flag_q, flag_clear[BIT_GND_OFFSET], set_vec[BIT_GND_OFFSET]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      spi_flag_q <= FLAGS_RST[BIT_SPI_FRAME];
    end else begin
      spi_flag_q <= sticky(spi_flag_q, flag_clear[BIT_SPI_FRAME], set_vec[BIT_SPI_FRAME]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bat_flag_q <= FLAGS_RST[BIT_BAT_FAIL];
    end else begin
      bat_flag_q <= sticky(bat_flag_q, flag_clear[BIT_BAT_FAIL], set_vec[BIT_BAT_FAIL]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sup_flag_q <= FLAGS_RST[BIT_SUPPLY_FAIL];
    end else begin
      sup_flag_q <= sticky(sup_flag_q, flag_clear[BIT_SUPPLY_FAIL], set_vec[BIT_SUPPLY_FAIL]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      canf_flag_q <= FLAGS_RST[BIT_CAN_FAIL];
    end else begin
      canf_flag_q <= sticky(canf_flag_q, flag_clear[BIT_CAN_FAIL], set_vec[BIT_CAN_FAIL]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      linf_flag_q <= FLAGS_RST[BIT_LIN_FAIL];
    end else begin
      linf_flag_q <= sticky(linf_flag_q, flag_clear[BIT_LIN_FAIL], set_vec[BIT_LIN_FAIL]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loc_flag_q <= FLAGS_RST[BIT_LOCAL_RESUME];
    end else begin
      loc_flag_q <= sticky(loc_flag_q, flag_clear[BIT_LOCAL_RESUME], set_vec[BIT_LOCAL_RESUME]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wdr_flag_q <= FLAGS_RST[BIT_WD_RESTART];
    end else begin
      wdr_flag_q <= sticky(wdr_flag_q, flag_clear[BIT_WD_RESTART], set_vec[BIT_WD_RESTART]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      canr_flag_q <= FLAGS_RST[BIT_CAN_RESUME];
    end else begin
      canr_flag_q <= sticky(canr_flag_q, flag_clear[BIT_CAN_RESUME], set_vec[BIT_CAN_RESUME]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      linr_flag_q <= FLAGS_RST[BIT_LIN_RESUME];
    end else begin
      linr_flag_q <= sticky(linr_flag_q, flag_clear[BIT_LIN_RESUME], set_vec[BIT_LIN_RESUME]);
    end
  end

  // -------------------------------------------------
  // Status word: wiring only, every bit is a flop
  // -------------------------------------------------
  always_comb begin
    irq_flags_q                   = FLAGS_RST;
    irq_flags_q[BIT_GND_OFFSET]   = gnd_flag_q;
    irq_flags_q[BIT_SPI_FRAME]    = spi_flag_q;
    irq_flags_q[BIT_BAT_FAIL]     = bat_flag_q;
    irq_flags_q[BIT_SUPPLY_FAIL]  = sup_flag_q;
    irq_flags_q[BIT_CAN_FAIL]     = canf_flag_q;
    irq_flags_q[BIT_LIN_FAIL]     = linf_flag_q;
    irq_flags_q[BIT_LOCAL_RESUME] = loc_flag_q;
    irq_flags_q[BIT_WD_RESTART]   = wdr_flag_q;
    irq_flags_q[BIT_CAN_RESUME]   = canr_flag_q;
    irq_flags_q[BIT_LIN_RESUME]   = linr_flag_q;
  end

  // -------------------------------------------------
  // Command gating: only well-formed frames pass on
  // -------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      spi_cmd_accept_q <= 1'b0;
    end else begin
      spi_cmd_accept_q <= frame_ok && spi_cmd_valid;
    end
  end
endmodule

// *** sbcif_flags_checker.sv ***
// Checker of flag setting and holding at the block's ports
`timescale 1ns/1ns
module sbcif_flags_checker
(
  input wire logic                         clk_sys,
  input wire logic                         rst_n,
  input wire logic                         ground_offset_diag,
  input wire logic                         battery_sense,
  input wire logic                         regulator_one_good,
  input wire logic                         regulator_two_good,
  input wire logic                         regulator_three_good,
  input wire logic [1:0]                   can_fail_status,
  input wire logic [1:0]                   lin_fail_status,
  input wire logic                         wake_pin,
  input wire logic                         wd_restart,
  input wire logic                         wd_off,
  input wire logic                         can_wake_event,
  input wire logic                         lin_wake_event,
  input wire logic [sbcif_pkg::FLAG_W-1:0] flag_clear,
  input wire logic [sbcif_pkg::FLAG_W-1:0] irq_flags_q,
  input wire logic                         spi_cmd_accept_q
);
  import sbcif_pkg::*;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Detectors prime on the first edge, so the past reset level guards them
  gnd_flag_a:
  assert property ($past(rst_n) && $changed(ground_offset_diag) |=> irq_flags_q[9]) else $error("gnd");
  bat_flag_a:
  assert property ($past(rst_n) && $fell(battery_sense) |=> irq_flags_q[7]) else $error("bat");
  can_fail_a:
  assert property ($past(rst_n) && $changed(can_fail_status) |=> irq_flags_q[5]) else $error("canf");
  wake_flag_a:
  assert property ($past(rst_n) && $fell(wake_pin) |=> irq_flags_q[3]) else $error("wake");
  wd_flag_a:
  assert property (wd_restart && wd_off |=> irq_flags_q[2]) else $error("wd set");
  wd_on_quiet_a:
  assert property (wd_restart && !wd_off && !irq_flags_q[2] |=> !irq_flags_q[2]) else $error("wd");
  can_resume_a:
  assert property (can_wake_event |=> irq_flags_q[1]) else $error("can wake");
  lin_resume_a:
  assert property (lin_wake_event |=> irq_flags_q[0]) else $error("lin wake");
  flag_hold_a:
  assert property ($past(rst_n) |-> ($past(irq_flags_q) & ~$past(flag_clear) & ~irq_flags_q) == '0)
    else $error("flag lost");
  accept_pulse_a:
  assert property (spi_cmd_accept_q |=> !spi_cmd_accept_q) else $error("accept");
  supply_flag_a:
  assert property ($past(rst_n) && ($fell(regulator_one_good) || $fell(regulator_two_good)
    || $fell(regulator_three_good)) |=> irq_flags_q[6]) else $error("supply flag not set");
  lin_fail_a:
  assert property ($past(rst_n) && $changed(lin_fail_status) |=> irq_flags_q[4])
    else $error("lin failure flag not set");
endmodule
bind sbcif_flags sbcif_flags_checker chk (.*);

// *** sbcif_host_model.sv ***
// Host model that frames SPI transfers
`timescale 1ns/1ns
module sbcif_host_model (
  input  wire logic clk_sys,
  output logic      spi_frame_active,
  output logic      spi_sclk_edge,
  output logic      spi_cmd_valid
);
  initial {spi_frame_active, spi_sclk_edge, spi_cmd_valid} = 3'h0;
  // Sends n clocks, the count the test passes in; there is no default
  task automatic frame(input int n);
    spi_frame_active = 1'h1;
    spi_cmd_valid = 1'h1;
    repeat (n) begin
      @(negedge clk_sys) spi_sclk_edge = 1'h1;
      @(negedge clk_sys) spi_sclk_edge = 1'h0;
    end
    spi_frame_active = 1'h0;
    repeat (2) @(negedge clk_sys);
    spi_cmd_valid = 1'h0;
  endtask
endmodule

// *** test_sbcif_flags.sv ***
// Self-checking bench for the interrupt flag block
`timescale 1ns/1ns
module test_sbcif_flags;
  import sbcif_pkg::*;
  logic              clk_sys, rst_n, frm, sclk, vld, wd_off, acc;
  logic [10:0]       p;
  logic [FLAG_W-1:0] clr, flags, exp, last;
  logic [10:0]       q[$];
  int                error_cnt, compares, n;
  int                fb[11] = '{9, 7, 6, 6, 6, 5, 4, 3, 2, 1, 0};
  sbcif_flags DUT (.clk_sys(clk_sys), .rst_n(rst_n), .spi_frame_active(frm),
    .spi_sclk_edge(sclk), .spi_cmd_valid(vld), .ground_offset_diag(p[0]),
    .battery_sense(~p[1]), .regulator_one_good(~p[2]), .regulator_two_good(~p[3]),
    .regulator_three_good(~p[4]), .can_fail_status({1'h0, p[5]}),
    .lin_fail_status({p[6], 1'h0}), .wake_pin(~p[7]), .wd_restart(p[8]), .wd_off(wd_off),
    .can_wake_event(p[9]), .lin_wake_event(p[10]), .flag_clear(clr),
    .irq_flags_q(flags), .spi_cmd_accept_q(acc));
  sbcif_host_model host (.clk_sys(clk_sys), .spi_frame_active(frm), .spi_sclk_edge(sclk),
    .spi_cmd_valid(vld));
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [10:0] s, input logic [10:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR flags expected %h seen %h", e, s);
    end
  endtask
  task automatic report_and_stop;
    if (q.size() != 0) error_cnt++;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Random clear bits beyond the target must not touch idle flags
  task automatic clear(input int b);
    repeat (3) @(negedge clk_sys);
    clr = 10'($urandom());
    clr[b] = 1'h1;
    exp[b] = 1'h0;
    q.push_back({1'h0, exp});
    @(negedge clk_sys) clr = '0;
    repeat (2) @(negedge clk_sys);
  endtask
  always @(negedge clk_sys) begin
    if (rst_n && (flags !== last || acc)) begin
      if (q.size() == 0) check({acc, flags}, {1'h0, last});
      else check({acc, flags}, q.pop_front());
      last = flags;
    end
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    {rst_n, p, clr, wd_off, last, exp, error_cnt, compares} = '0;
    void'($urandom(12821));
    repeat (4) @(negedge clk_sys);
    rst_n = 1'h1;
    repeat (2) @(negedge clk_sys);
    wd_off = 1'h1;
    for (int k = 0; k < 11; k++) begin
      p[k] = 1'h1;
      exp[fb[k]] = 1'h1;
      q.push_back({1'h0, exp});
      @(negedge clk_sys) p[k] = 1'h0;
      clear(fb[k]);
      $display("event %0d done", k);
    end
    wd_off = 1'h0;
    p[8] = 1'h1;
    @(negedge clk_sys) p[8] = 1'h0;
    repeat (3) @(negedge clk_sys);
    $display("watchdog on done");
    for (int i = 0; i < 3; i++) begin
      n = (i == 0) ? 16 : (i == 1) ? $urandom_range(40, 17) : $urandom_range(15, 1);
      exp[8] = (n != 16);
      q.push_back({n == 16, exp});
      host.frame(n);
      if (n != 16) clear(8);
      else repeat (3) @(negedge clk_sys);
      $display("frame of %0d done", n);
    end
    report_and_stop();
  end
endmodule
